// ===== feature_id_pkg.sv
// Constants for the feature identification register bank.
// Assumes a core pipeline that presents one system register access at a time.
package feature_id_pkg;

	// Privilege level codes on the request port
	localparam logic [1:0] LEVEL_USER    = 2'h0;
	localparam logic [1:0] LEVEL_KERNEL  = 2'h1;
	localparam logic [1:0] LEVEL_HYP     = 2'h2;
	localparam logic [1:0] LEVEL_MONITOR = 2'h3;

	// Trap syndrome class for a trapped system register access
	localparam logic [5:0] SYNDROME_SYSREG = 6'h18;

	// System register encodings, common part and per-register CRm and op2
	localparam logic [1:0] ENC_OP0    = 2'h3;
	localparam logic [2:0] ENC_OP1    = 3'h0;
	localparam logic [3:0] ENC_CRN    = 4'h0;
	localparam logic [3:0] ENC_CRM_PV = 4'h4;
	localparam logic [3:0] ENC_CRM_DB = 4'h5;
	localparam logic [2:0] ENC_OP2_PF = 3'h1;
	localparam logic [2:0] ENC_OP2_VF = 3'h4;
	localparam logic [2:0] ENC_OP2_DF = 3'h0;

	// Field positions (low bit of each 4-bit field)
	localparam int unsigned PF_RANDOM_TRAP  = 28;
	localparam int unsigned PF_MATRIX_EXT   = 24;
	localparam int unsigned PF_PART_FRAC    = 16;
	localparam int unsigned PF_MEM_TAG      = 8;
	localparam int unsigned PF_STORE_BYPASS = 4;
	localparam int unsigned PF_BRANCH_ID    = 0;

	localparam int unsigned VF_DOUBLE_MM  = 56;
	localparam int unsigned VF_SINGLE_MM  = 52;
	localparam int unsigned VF_INT8_MM    = 44;
	localparam int unsigned VF_SM_CIPHER  = 40;
	localparam int unsigned VF_SHA3       = 32;
	localparam int unsigned VF_BFLOAT     = 20;
	localparam int unsigned VF_BIT_PERM   = 16;
	localparam int unsigned VF_AES        = 4;
	localparam int unsigned VF_VERSION    = 0;

	localparam int unsigned DF_ZERO_GUEST = 60;
	localparam int unsigned DF_BRANCH_REC = 52;
	localparam int unsigned DF_MT_MONITOR = 48;
	localparam int unsigned DF_TRACE_BUF  = 44;
	localparam int unsigned DF_SELF_TRACE = 40;
	localparam int unsigned DF_DBL_LOCK   = 36;
	localparam int unsigned DF_STAT_PROF  = 32;
	localparam int unsigned DF_CTX_BRK    = 28;
	localparam int unsigned DF_WATCH      = 20;
	localparam int unsigned DF_BREAK      = 12;
	localparam int unsigned DF_PERF_MON   = 8;
	localparam int unsigned DF_TRACE_IF   = 4;
	localparam int unsigned DF_DEBUG_VER  = 0;

	// Field values
	localparam logic [3:0] VAL_ZERO       = 4'h0;
	localparam logic [3:0] VAL_ONE        = 4'h1;
	localparam logic [3:0] VAL_TWO        = 4'h2;
	localparam logic [3:0] VAL_TAG_FULL   = 4'h3;
	localparam logic [3:0] VAL_NOT_IMPL   = 4'hF;
	localparam logic [3:0] VAL_CTX_BRK    = 4'h1;
	localparam logic [3:0] VAL_WATCH      = 4'h3;
	localparam logic [3:0] VAL_BREAK      = 4'h5;
	localparam logic [3:0] VAL_PERF_MON   = 4'h7;
	localparam logic [3:0] VAL_DEBUG_VER  = 4'h9;

	// Reset value of the response data
	localparam logic [63:0] DATA_RESET = 64'h0;

endpackage

// ===== access_check_if.sv
// Carries one access-check question and its answer between the bank and its checker.
// Assumes both ends sit on the same clock; the answer is combinational.
`timescale 1ns/10ps
interface access_check_if;
	logic       [1:0] level;
	logic             hyp_enabled;
	logic             host_trap_general;
	logic             id_group3_trap;
	logic             trap;
	logic       [1:0] target_level;

	modport requester (output level, output hyp_enabled, output host_trap_general,
		output id_group3_trap, input trap, input target_level);
	modport decider (input level, input hyp_enabled, input host_trap_general,
		input id_group3_trap, output trap, output target_level);
endinterface

// ===== pin_synchroniser.sv
// Three-flop synchroniser with an agreement filter for one slow pin.
// Assumes the pin changes rarely compared with the core clock.
`timescale 1ns/10ps
module pin_synchroniser
	import feature_id_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Pin and filtered level
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
	} sync_s;

	sync_s state;
	sync_s next_state;

	// First stage feeds only the second stage
	always_comb begin
		next_state = state;
		next_state.s1 = pin;
		next_state.s2 = state.s1;
		next_state.s3 = state.s2;
		if (state.s2 == state.s3) begin
			next_state.stable = state.s3;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign level = state.stable;
endmodule

// ===== access_checker.sv
// Decides whether an identification register read traps and to which level.
// Assumes the requester only asks for encodings the bank maps.
`timescale 1ns/10ps
module access_checker
	import feature_id_pkg::*;
(
	// Question and answer
	access_check_if.decider chk
);
	always_comb begin
		chk.trap = 1'b0;
		chk.target_level = LEVEL_KERNEL;
		case (chk.level)
			LEVEL_USER: begin
				chk.trap = 1'b1;
				if (chk.hyp_enabled && chk.host_trap_general) begin
					chk.target_level = LEVEL_HYP;
				end else begin
					chk.target_level = LEVEL_KERNEL;
				end
			end
			LEVEL_KERNEL: begin
				if (chk.hyp_enabled && chk.id_group3_trap) begin
					chk.trap = 1'b1;
					chk.target_level = LEVEL_HYP;
				end
			end
			// Higher levels always see the contents
			LEVEL_HYP, LEVEL_MONITOR: begin
				chk.trap = 1'b0;
			end
			default: begin
				chk.trap = 1'b0;
			end
		endcase
	end
endmodule

// ===== feature_id_register_bank.sv
// Feature identification register bank: three read-only 64-bit registers.
// Assumes the pipeline presents at most one access per cycle and accepts the answer one cycle later.
//
// Functional notes
// - User-level read traps, class 0x18, to hypervisor if enabled and trap-general, else kernel.
// - Kernel-level read traps to hypervisor if enabled and group-3 trap set, else returns.
// - Hypervisor and monitor level reads always return contents, no trap check.
// - Processor features 1 selected by op0 3, op1 0, CRn 0, CRm 4, op2 1.
// - Vector features 0 selected by op0 3, op1 0, CRn 0, CRm 4, op2 4.
// - Debug features 0 selected by op0 3, op1 0, CRn 0, CRm 5, op2 0.
// - Processor features 1 bits 63:32, 23:20 and 15:12 read zero.
// - Random-number trap field 31:28 reads zero, trapping unsupported.
// - Matrix extension field 27:24 reads zero, not implemented.
// - Partitioning fraction field 19:16 reads one.
// - Memory tagging field reads one with tag broadcast low, three when high.
// - Store-bypass-safe field 7:4 reads two.
// - Branch target identification field 3:0 reads one.
// - Vector double and single matrix multiply fields read zero.
// - Int8 matrix, bfloat, bit permute and vector version fields read one.
// - Vector SM cipher and SHA3 fields read one with crypto enabled, else zero.
// - Vector AES field reads two with crypto enabled, else zero.
// - Vector features 0 reserved bits 63:60, 51:48, 39:36, 31:24, 15:8 read zero.
// - Zero guest counters, trace buffer, self-hosted trace read one; branch record, profiling zero.
// - Multithread monitor and double-lock fields read all ones, not implemented.
// - Breakpoint and watchpoint counts hold count minus one: 1, 3, 5.
// - Debug version reads 9, trace interface one, perf monitor version code.
`timescale 1ns/10ps
module feature_id_register_bank
	import feature_id_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Access request from the pipeline
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [1:0]  req_op0,
	input  wire logic [2:0]  req_op1,
	input  wire logic [3:0]  req_crn,
	input  wire logic [3:0]  req_crm,
	input  wire logic [2:0]  req_op2,
	// Privilege context of the request
	input  wire logic [1:0]  req_level,
	input  wire logic        hyp_enabled,
	input  wire logic        host_trap_general,
	input  wire logic        id_group3_trap,
	// Configuration pins
	input  wire logic        tag_broadcast_input,
	input  wire logic        crypto_enabled,
	// Answer to the pipeline
	output logic             rsp_valid,
	output logic [63:0]      rsp_data,
	output logic             rsp_trap,
	output logic [1:0]       rsp_target_level,
	output logic [5:0]       rsp_syndrome_class,
	output logic             rsp_unmapped,
	output logic             rsp_write_ignored
);
	typedef enum {
		SEL_NONE,
		SEL_PROC_1,
		SEL_VECTOR_0,
		SEL_DEBUG_0
	} select_e;

	typedef struct packed {
		logic        rsp_valid;
		logic [63:0] rsp_data;
		logic        rsp_trap;
		logic [1:0]  rsp_target_level;
		logic [5:0]  rsp_syndrome_class;
		logic        rsp_unmapped;
		logic        rsp_write_ignored;
	} bank_s;

	bank_s   state;
	bank_s   next_state;
	select_e sel;
	logic    tag_level;
	logic    crypto_level;

	access_check_if chk_bus ();

	// Pins are slow straps; filtered to avoid a torn field value
	pin_synchroniser u_tag_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin     (tag_broadcast_input),
		.level   (tag_level)
	);

	pin_synchroniser u_crypto_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin     (crypto_enabled),
		.level   (crypto_level)
	);

	access_checker u_checker (
		.chk (chk_bus)
	);

	assign chk_bus.level             = req_level;
	assign chk_bus.hyp_enabled       = hyp_enabled;
	assign chk_bus.host_trap_general = host_trap_general;
	assign chk_bus.id_group3_trap    = id_group3_trap;

	// Places a 4-bit field into a 64-bit word
	function automatic logic [63:0] put_field(input logic [63:0] word, input int unsigned lsb,
		input logic [3:0] val);
		logic [63:0] shifted;
		shifted = 64'(val) << lsb;
		return word | shifted;
	endfunction

	// Decodes a system register encoding to a bank entry
	function automatic select_e decode(input logic [1:0] op0, input logic [2:0] op1,
		input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2);
		select_e s;
		s = SEL_NONE;
		if (op0 == ENC_OP0 && op1 == ENC_OP1 && crn == ENC_CRN) begin
			if (crm == ENC_CRM_PV && op2 == ENC_OP2_PF) begin
				s = SEL_PROC_1;
			end else if (crm == ENC_CRM_PV && op2 == ENC_OP2_VF) begin
				s = SEL_VECTOR_0;
			end else if (crm == ENC_CRM_DB && op2 == ENC_OP2_DF) begin
				s = SEL_DEBUG_0;
			end
		end
		return s;
	endfunction

	// Processor features 1; unlisted bits stay zero
	function automatic logic [63:0] proc_feature_1(input logic tag_bcast);
		logic [63:0] w;
		w = 64'h0;
		w = put_field(w, PF_RANDOM_TRAP, VAL_ZERO);
		w = put_field(w, PF_MATRIX_EXT, VAL_ZERO);
		w = put_field(w, PF_PART_FRAC, VAL_ONE);
		w = put_field(w, PF_MEM_TAG, tag_bcast ? VAL_TAG_FULL : VAL_ONE);
		w = put_field(w, PF_STORE_BYPASS, VAL_TWO);
		w = put_field(w, PF_BRANCH_ID, VAL_ONE);
		return w;
	endfunction

	// Vector features 0; crypto fields follow the enable pin
	function automatic logic [63:0] vector_feature_0(input logic crypto);
		logic [63:0] w;
		w = 64'h0;
		w = put_field(w, VF_DOUBLE_MM, VAL_ZERO);
		w = put_field(w, VF_SINGLE_MM, VAL_ZERO);
		w = put_field(w, VF_INT8_MM, VAL_ONE);
		w = put_field(w, VF_SM_CIPHER, crypto ? VAL_ONE : VAL_ZERO);
		w = put_field(w, VF_SHA3, crypto ? VAL_ONE : VAL_ZERO);
		w = put_field(w, VF_BFLOAT, VAL_ONE);
		w = put_field(w, VF_BIT_PERM, VAL_ONE);
		w = put_field(w, VF_AES, crypto ? VAL_TWO : VAL_ZERO);
		w = put_field(w, VF_VERSION, VAL_ONE);
		return w;
	endfunction

	// Debug features 0; fully fixed
	function automatic logic [63:0] debug_feature_0();
		logic [63:0] w;
		w = 64'h0;
		w = put_field(w, DF_ZERO_GUEST, VAL_ONE);
		w = put_field(w, DF_BRANCH_REC, VAL_ZERO);
		w = put_field(w, DF_MT_MONITOR, VAL_NOT_IMPL);
		w = put_field(w, DF_TRACE_BUF, VAL_ONE);
		w = put_field(w, DF_SELF_TRACE, VAL_ONE);
		w = put_field(w, DF_DBL_LOCK, VAL_NOT_IMPL);
		w = put_field(w, DF_STAT_PROF, VAL_ZERO);
		w = put_field(w, DF_CTX_BRK, VAL_CTX_BRK);
		w = put_field(w, DF_WATCH, VAL_WATCH);
		w = put_field(w, DF_BREAK, VAL_BREAK);
		w = put_field(w, DF_PERF_MON, VAL_PERF_MON);
		w = put_field(w, DF_TRACE_IF, VAL_ONE);
		w = put_field(w, DF_DEBUG_VER, VAL_DEBUG_VER);
		return w;
	endfunction

	assign sel = decode(req_op0, req_op1, req_crn, req_crm, req_op2);

	always_comb begin
		next_state = state;
		next_state.rsp_valid = req_valid;
		next_state.rsp_data = DATA_RESET;
		next_state.rsp_trap = 1'b0;
		next_state.rsp_target_level = LEVEL_USER;
		next_state.rsp_syndrome_class = 6'h00;
		next_state.rsp_unmapped = 1'b0;
		next_state.rsp_write_ignored = 1'b0;
		if (req_valid) begin
			if (req_write) begin
				// Contents come from constants and pins only
				next_state.rsp_write_ignored = 1'b1;
			end else if (sel == SEL_NONE) begin
				next_state.rsp_unmapped = 1'b1;
			end else if (chk_bus.trap) begin
				// Trap answer carries no data, so nothing leaks to a lower level
				next_state.rsp_trap = 1'b1;
				next_state.rsp_target_level = chk_bus.target_level;
				next_state.rsp_syndrome_class = SYNDROME_SYSREG;
			end else begin
				case (sel)
					SEL_PROC_1: begin
						next_state.rsp_data = proc_feature_1(tag_level);
					end
					SEL_VECTOR_0: begin
						next_state.rsp_data = vector_feature_0(crypto_level);
					end
					SEL_DEBUG_0: begin
						next_state.rsp_data = debug_feature_0();
					end
					default: begin
						next_state.rsp_data = DATA_RESET;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rsp_valid          = state.rsp_valid;
	assign rsp_data           = state.rsp_data;
	assign rsp_trap           = state.rsp_trap;
	assign rsp_target_level   = state.rsp_target_level;
	assign rsp_syndrome_class = state.rsp_syndrome_class;
	assign rsp_unmapped       = state.rsp_unmapped;
	assign rsp_write_ignored  = state.rsp_write_ignored;

	// Checks
	logic rd_hit;
	assign rd_hit = req_valid && !req_write && sel != SEL_NONE;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	property p_user_trap;
		rd_hit && req_level == LEVEL_USER
		|=> rsp_trap && rsp_syndrome_class == 6'h18 && rsp_data == 64'h0
			&& rsp_target_level == (($past(hyp_enabled) && $past(host_trap_general)) ? LEVEL_HYP : LEVEL_KERNEL);
	endproperty
	a_user_trap: assert property (p_user_trap) else $error("user read not trapped correctly");

	property p_kernel_check;
		rd_hit && req_level == LEVEL_KERNEL
		|=> rsp_trap == ($past(hyp_enabled) && $past(id_group3_trap))
			&& (!rsp_trap || (rsp_target_level == LEVEL_HYP && rsp_syndrome_class == 6'h18));
	endproperty
	a_kernel_check: assert property (p_kernel_check) else $error("kernel read trap decision wrong");

	property p_high_no_trap;
		rd_hit && req_level[1] |=> rsp_valid && !rsp_trap && rsp_data != 64'h0;
	endproperty
	a_high_no_trap: assert property (p_high_no_trap) else $error("high level read trapped");

	property p_proc_decode;
		req_valid && !req_write && req_level == LEVEL_MONITOR && req_op0 == 2'h3 && req_op1 == 3'h0
			&& req_crn == 4'h0 && req_crm == 4'h4 && req_op2 == 3'h1
		|=> !rsp_unmapped && rsp_data[23:16] == 8'h01 && rsp_data[7:0] == 8'h21;
	endproperty
	a_proc_decode: assert property (p_proc_decode) else $error("processor features 1 decode wrong");

	property p_vector_decode;
		req_valid && !req_write && req_level == LEVEL_HYP && req_crm == 4'h4 && req_op2 == 3'h4
			&& req_op0 == 2'h3 && req_op1 == 3'h0 && req_crn == 4'h0
		|=> !rsp_unmapped && rsp_data[3:0] == 4'h1 && rsp_data[47:44] == 4'h1;
	endproperty
	a_vector_decode: assert property (p_vector_decode) else $error("vector features 0 decode wrong");

	property p_debug_decode;
		req_valid && !req_write && req_level == LEVEL_HYP && req_crm == 4'h5 && req_op2 == 3'h0
			&& req_op0 == 2'h3 && req_op1 == 3'h0 && req_crn == 4'h0
		|=> rsp_data == 64'h100F_11F0_1030_5719;
	endproperty
	a_debug_decode: assert property (p_debug_decode) else $error("debug features 0 value wrong");

	property p_proc_reserved;
		rd_hit && sel == SEL_PROC_1 && !chk_bus.trap
		|=> rsp_data[63:32] == 32'h0 && rsp_data[31:24] == 8'h00 && rsp_data[23:20] == 4'h0
			&& rsp_data[15:12] == 4'h0;
	endproperty
	a_proc_reserved: assert property (p_proc_reserved) else $error("processor reserved bits set");

	property p_tag_field;
		rd_hit && sel == SEL_PROC_1 && !chk_bus.trap
		|=> rsp_data[11:8] == ($past(tag_level) ? 4'h3 : 4'h1);
	endproperty
	a_tag_field: assert property (p_tag_field) else $error("memory tagging field wrong");

	property p_crypto_fields;
		rd_hit && sel == SEL_VECTOR_0 && !chk_bus.trap
		|=> $past(crypto_level) ? (rsp_data[43:32] == 12'h101 && rsp_data[7:4] == 4'h2)
			: (rsp_data[43:32] == 12'h000 && rsp_data[7:4] == 4'h0);
	endproperty
	a_crypto_fields: assert property (p_crypto_fields) else $error("vector crypto fields wrong");

	property p_vector_reserved;
		rd_hit && sel == SEL_VECTOR_0 && !chk_bus.trap
		|=> rsp_data[63:52] == 12'h000 && rsp_data[51:48] == 4'h0 && rsp_data[31:24] == 8'h00
			&& rsp_data[15:8] == 8'h00 && rsp_data[23:16] == 8'h11;
	endproperty
	a_vector_reserved: assert property (p_vector_reserved) else $error("vector reserved bits set");

	property p_write_ignored;
		req_valid && req_write |=> rsp_valid && rsp_write_ignored && rsp_data == 64'h0 && !rsp_trap;
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write not ignored");

	property p_valid_follows;
		req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid));
	endproperty
	a_valid_follows: assert property (p_valid_follows) else $error("answer timing wrong");
endmodule

// ===== pipeline_model.sv
// Pipeline model that issues identification register accesses to the bank.
// Assumes callers enter its tasks just after a rising edge of sys_clk.
`timescale 1ns/10ps
module pipeline_model
	import feature_id_pkg::*;
(
	// Clock
	input  wire logic sys_clk,
	// Access request
	output logic       req_valid,
	output logic       req_write,
	output logic [1:0] req_op0,
	output logic [2:0] req_op1,
	output logic [3:0] req_crn,
	output logic [3:0] req_crm,
	output logic [2:0] req_op2,
	// Privilege context
	output logic [1:0] req_level,
	output logic       hyp_enabled,
	output logic       host_trap_general,
	output logic       id_group3_trap
);
	initial begin
		req_valid         = 1'b0;
		req_write         = 1'b0;
		req_op0           = 2'h0;
		req_op1           = 3'h0;
		req_crn           = 4'h0;
		req_crm           = 4'h0;
		req_op2           = 3'h0;
		req_level         = 2'h0;
		hyp_enabled       = 1'b0;
		host_trap_general = 1'b0;
		id_group3_trap    = 1'b0;
	end

	// One request, held up to the taking edge; left up for back-to-back use
	task automatic access(input logic wr, input logic [3:0] crm, input logic [2:0] op2,
		input logic [1:0] lvl, input logic [2:0] ctl);
		req_valid         = 1'b1;
		req_write         = wr;
		req_op0           = ENC_OP0;
		req_op1           = ENC_OP1;
		req_crn           = ENC_CRN;
		req_crm           = crm;
		req_op2           = op2;
		req_level         = lvl;
		hyp_enabled       = ctl[2];
		host_trap_general = ctl[1];
		id_group3_trap    = ctl[0];
		@(posedge sys_clk);
		#1;
	endtask

	// Idle lines show the inverse of the last value, never a stale copy
	task automatic release_bus();
		req_valid         = 1'b0;
		req_write         = ~req_write;
		req_op0           = ~req_op0;
		req_op1           = ~req_op1;
		req_crn           = ~req_crn;
		req_crm           = ~req_crm;
		req_op2           = ~req_op2;
		req_level         = ~req_level;
		hyp_enabled       = ~hyp_enabled;
		host_trap_general = ~host_trap_general;
		id_group3_trap    = ~id_group3_trap;
		@(posedge sys_clk);
		#1;
	endtask
endmodule

// ===== tb_feature_id_register_bank.sv
// Self-checking bench for the feature identification register bank.
// Assumes one-cycle registered answers and a pin filter of at most four edges.
`timescale 1ns/10ps
module tb_feature_id_register_bank
	import feature_id_pkg::*;
;
	logic        sys_clk, rst, tag_broadcast_input, crypto_enabled;
	logic        req_valid, req_write, hyp_enabled, host_trap_general, id_group3_trap;
	logic [1:0]  req_op0, req_level, rsp_target_level;
	logic [2:0]  req_op1, req_op2;
	logic [3:0]  req_crn, req_crm;
	logic        rsp_valid, rsp_trap, rsp_unmapped, rsp_write_ignored;
	logic [63:0] rsp_data;
	logic [5:0]  rsp_syndrome_class;
	int          errors, total_checks;

	// Expected words, worked out field by field
	localparam logic [63:0] PF_TAG_LOW  = 64'h0000_0000_0001_0121;
	localparam logic [63:0] PF_TAG_HIGH = 64'h0000_0000_0001_0321;
	localparam logic [63:0] VF_PLAIN    = 64'h0000_1000_0011_0001;
	localparam logic [63:0] VF_CRYPTO   = 64'h0000_1101_0011_0021;
	localparam logic [63:0] DF_WORD     = 64'h100F_11F0_1030_5719;

	pipeline_model pm (.sys_clk(sys_clk), .req_valid(req_valid), .req_write(req_write), .req_op0(req_op0),
		.req_op1(req_op1), .req_crn(req_crn), .req_crm(req_crm), .req_op2(req_op2), .req_level(req_level),
		.hyp_enabled(hyp_enabled), .host_trap_general(host_trap_general), .id_group3_trap(id_group3_trap));

	feature_id_register_bank dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
		.req_op0(req_op0), .req_op1(req_op1), .req_crn(req_crn), .req_crm(req_crm), .req_op2(req_op2),
		.req_level(req_level), .hyp_enabled(hyp_enabled), .host_trap_general(host_trap_general),
		.id_group3_trap(id_group3_trap), .tag_broadcast_input(tag_broadcast_input),
		.crypto_enabled(crypto_enabled), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_trap(rsp_trap),
		.rsp_target_level(rsp_target_level), .rsp_syndrome_class(rsp_syndrome_class),
		.rsp_unmapped(rsp_unmapped), .rsp_write_ignored(rsp_write_ignored));

	task automatic chk_flag(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_data(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_level(input string what, input logic [1:0] exp, input logic [1:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_class(input string what, input logic [5:0] exp, input logic [5:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Whole answer, looked at in the one cycle it stands
	task automatic expect_rsp(input string what, input logic [63:0] d, input logic tr, input logic [1:0] tl,
		input logic um, input logic wi);
		chk_flag({what, " valid"}, 1'b1, rsp_valid);
		chk_data({what, " data"}, d, rsp_data);
		chk_flag({what, " trap"}, tr, rsp_trap);
		chk_level({what, " target"}, tl, rsp_target_level);
		chk_class({what, " class"}, tr ? 6'h18 : 6'h00, rsp_syndrome_class);
		chk_flag({what, " unmapped"}, um, rsp_unmapped);
		chk_flag({what, " write ignored"}, wi, rsp_write_ignored);
	endtask

	task automatic end_quiet(input string what);
		pm.release_bus();
		chk_flag({what, " pulse ends"}, 1'b0, rsp_valid);
		chk_data({what, " data clears"}, 64'h0000_0000_0000_0000, rsp_data);
	endtask

	// Monitor-level reads of processor and debug features, hypervisor-level read of vector features, back to back, after pins settle
	task automatic t_read_all(input logic crypto, input logic tag);
		crypto_enabled      = crypto;
		tag_broadcast_input = tag;
		repeat (6) @(posedge sys_clk);
		#1;
		pm.access(1'b0, ENC_CRM_PV, ENC_OP2_PF, LEVEL_MONITOR, 3'h7);
		expect_rsp("proc1", tag ? PF_TAG_HIGH : PF_TAG_LOW, 1'b0, 2'h0, 1'b0, 1'b0);
		pm.access(1'b0, ENC_CRM_PV, ENC_OP2_VF, LEVEL_HYP, 3'h7);
		expect_rsp("vector0", crypto ? VF_CRYPTO : VF_PLAIN, 1'b0, 2'h0, 1'b0, 1'b0);
		pm.access(1'b0, ENC_CRM_DB, ENC_OP2_DF, LEVEL_MONITOR, 3'h7);
		expect_rsp("debug0", DF_WORD, 1'b0, 2'h0, 1'b0, 1'b0);
		end_quiet("read");
	endtask

	// Every level against every trap control setting
	task automatic t_traps();
		logic [1:0] lvl;
		logic [2:0] ctl;
		logic       tr;
		logic [1:0] tl;
		for (int i = 0; i < 32; i++) begin
			lvl = 2'(i >> 3);
			ctl = 3'(i);
			tr  = (lvl == 2'h0) || (lvl == 2'h1 && ctl[2] && ctl[0]);
			tl  = (lvl == 2'h0) ? ((ctl[2] && ctl[1]) ? 2'h2 : 2'h1) : (tr ? 2'h2 : 2'h0);
			pm.access(1'b0, ENC_CRM_DB, ENC_OP2_DF, lvl, ctl);
			expect_rsp("trap table", tr ? 64'h0 : DF_WORD, tr, tl, 1'b0, 1'b0);
		end
		end_quiet("trap");
	endtask

	// Writes at kernel level under trap-worthy context and at monitor level are discarded and leave contents alone
	task automatic t_write();
		pm.access(1'b1, ENC_CRM_PV, ENC_OP2_PF, LEVEL_KERNEL, 3'h5);
		expect_rsp("write proc1", 64'h0, 1'b0, 2'h0, 1'b0, 1'b1);
		pm.access(1'b1, ENC_CRM_DB, ENC_OP2_DF, LEVEL_MONITOR, 3'h0);
		expect_rsp("write debug0", 64'h0, 1'b0, 2'h0, 1'b0, 1'b1);
		pm.access(1'b0, ENC_CRM_DB, ENC_OP2_DF, LEVEL_KERNEL, 3'h0);
		expect_rsp("reread debug0", DF_WORD, 1'b0, 2'h0, 1'b0, 1'b0);
		pm.access(1'b0, ENC_CRM_PV, ENC_OP2_PF, LEVEL_HYP, 3'h0);
		expect_rsp("reread proc1", PF_TAG_HIGH, 1'b0, 2'h0, 1'b0, 1'b0);
		end_quiet("write");
	endtask

	// Neighbouring encodings select none of the three
	task automatic t_unmapped();
		pm.access(1'b0, ENC_CRM_PV, 3'h0, LEVEL_MONITOR, 3'h0);
		expect_rsp("crm4 op2 0", 64'h0, 1'b0, 2'h0, 1'b1, 1'b0);
		pm.access(1'b0, ENC_CRM_DB, 3'h1, LEVEL_USER, 3'h6);
		expect_rsp("crm5 op2 1", 64'h0, 1'b0, 2'h0, 1'b1, 1'b0);
		pm.access(1'b0, ENC_CRM_PV, 3'h5, LEVEL_KERNEL, 3'h5);
		expect_rsp("crm4 op2 5", 64'h0, 1'b0, 2'h0, 1'b1, 1'b0);
		end_quiet("unmapped");
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Hang guard well past the whole sequence
	initial begin
		#40000;
		errors++;
		$display("[FAIL] run length expected finish seen stall");
		end_of_test();
	end

	initial begin
		errors              = 0;
		total_checks        = 0;
		rst                 = 1'b1;
		tag_broadcast_input = 1'b0;
		crypto_enabled      = 1'b0;
		repeat (10) @(posedge sys_clk);
		#1;
		chk_flag("reset valid", 1'b0, rsp_valid);
		chk_data("reset data", 64'h0, rsp_data);
		rst = 1'b0;
		t_read_all(1'b0, 1'b0);
		t_traps();
		t_read_all(1'b1, 1'b1);
		t_write();
		t_unmapped();
		t_read_all(1'b0, 1'b1);
		end_of_test();
	end
endmodule
